// >>> core/adc_cmd_dev.sv
/*
  Device end of the serial command decoder with frame-done output.
// Contract
// - done falls after last bit shifted
// - two-bit field sets done delay
// - done drives next device chip select
// - single master: done wired to own select
// - ten commands, sixteen bits, first word
// - controller pads low bits with zeros
// - decode after frame end, act immediately
// - recognized command answered next frame
// - standby command, echoed acknowledge
// - wakeup command, echoed acknowledge
// - lock admits only null, reads, unlock
// - unlock leaves power-on or locked state
// - single read returns register content word
// - multi read returns count plus one
// - single write, answer updated content
// - multi write data, two registers per word
// - frame grows count/2; prefix-010 acknowledge
// - response in top sixteen bits
// - response confirms previous frame's command
// - bits below response read zero
// - content word is prefix, address, data
  Assumes link inputs are asynchronous to clk and slow against it.
*/
`timescale 1ns/1ps
module adc_cmd_dev #(
  parameter int WORD_BITS = adc_cmd_pkg::WORD_BITS_DEF,
  parameter int FRAME_WORDS = adc_cmd_pkg::FRAME_WORDS_DEF,
  parameter int DONE_STEP = adc_cmd_pkg::DONE_STEP_CYC,
  parameter logic [7:0] DEV_ID = 8'h5A  // arbitrary value
)(
  input wire logic clk,
  input wire logic arst_n,
  adc_spi_if.dev link,
  input wire logic [7:0] statusIn,
  output logic standby,
  output logic locked,
  output logic awaitUnlock,
  output logic cmdStrobe,
  output logic [15:0] lastCmd
);
  // ---------------------------------------------------------------
  // constants and helpers
  // ---------------------------------------------------------------
  localparam logic [5:0] LAST_BIT = 6'(WORD_BITS - 1);
  localparam logic [5:0] CMD_END = 6'(adc_cmd_pkg::CMD_W - 1);
  localparam logic [15:0] READY_W = {adc_cmd_pkg::READY_HI, DEV_ID};

  logic [7:0] regFile_r [0:adc_cmd_pkg::NUM_REGS-1];

  // response in the top bits, zeros below
  function automatic logic [WORD_BITS-1:0] pad(input logic [15:0] w);
    pad = WORD_BITS'({w, {WORD_BITS{1'b0}}} >> adc_cmd_pkg::CMD_W);
  endfunction

  // offset within count and address inside the map
  function automatic logic inRange(input logic [9:0] off,
    input logic [7:0] n, input logic [9:0] a);
    inRange = (off <= {2'b00, n}) && (a < 10'(adc_cmd_pkg::NUM_REGS));
  endfunction

  // register read; status comes live from the fault logic
  // stored byte and status are arguments so callers follow their changes
  function automatic logic [7:0] rdByte(input logic [9:0] a,
    input logic ok, input logic [7:0] v, input logic [7:0] s);
    if (!ok)
      rdByte = 8'h00;
    else if (a[4:0] == adc_cmd_pkg::STAT_ADDR)
      rdByte = s;
    else
      rdByte = v;
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers and edges
  // ---------------------------------------------------------------
  logic sclkS1, sclkS2, sclkD;  // serial clock stages
  logic csS1, csS2, csD;        // select stages
  logic dinS1, dinS2;           // data stages

  // two stages before any logic; a third for edge finding
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {sclkS1, sclkS2, sclkD} <= 3'h0;
      {csS1, csS2, csD} <= 3'h7;
      {dinS1, dinS2} <= 2'h0;
    end
    else
    begin
      {sclkS1, sclkS2, sclkD} <= {link.sclk, sclkS1, sclkS2};
      {csS1, csS2, csD} <= {link.csN, csS1, csS2};
      {dinS1, dinS2} <= {link.din, dinS1};
    end
  end

  wire inFrame = ~csS2;
  wire sclkRise = sclkS2 & ~sclkD;
  wire sclkFall = ~sclkS2 & sclkD;
  wire csFall = ~csS2 & csD;
  wire csRise = csS2 & ~csD;

  // ---------------------------------------------------------------
  // frame bookkeeping
  // ---------------------------------------------------------------
  logic [5:0] bitIdx_r;     // falls counted within word
  logic [8:0] wordIdx_r;    // word within frame
  logic started_r;          // at least one fall seen
  logic frameEnd_r;         // last bit taken
  logic [14:0] rxSr_r;      // recent input bits
  logic [15:0] cmdWord_r;   // command of current frame
  logic [7:0] cmdExt_r;     // words added by a multi write
  logic [7:0] respExt_r;    // words added by a multi read answer
  logic [15:0] respWord_r;  // answer for the next frame
  logic respMulti_r;        // answer carries register words
  logic [WORD_BITS-1:0] txSr_r;

  wire [15:0] rxTop = {rxSr_r, dinS2};
  wire [7:0] extMax = (cmdExt_r > respExt_r) ? cmdExt_r : respExt_r;
  wire [8:0] lastWord = 9'(FRAME_WORDS - 1) + {1'b0, extMax};
  wire takeBit = sclkFall & inFrame & ~frameEnd_r;
  wire lastFall = takeBit & (wordIdx_r == lastWord)
    & (bitIdx_r == LAST_BIT);
  wire cmdDone = takeBit & (wordIdx_r == 9'h000) & (bitIdx_r == CMD_END);

  // input side: count falls, catch command in first word
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bitIdx_r <= 6'h00;
      wordIdx_r <= 9'h000;
      started_r <= 1'b0;
      frameEnd_r <= 1'b0;
      rxSr_r <= 15'h0000;
      cmdWord_r <= 16'h0000;
      cmdExt_r <= 8'h00;
    end
    else if (csFall)
    begin
      bitIdx_r <= 6'h00;
      wordIdx_r <= 9'h000;
      started_r <= 1'b0;
      frameEnd_r <= 1'b0;
      cmdExt_r <= 8'h00;
    end
    else if (takeBit)
    begin
      started_r <= 1'b1;
      rxSr_r <= rxTop[14:0];
      frameEnd_r <= lastFall;
      bitIdx_r <= (bitIdx_r == LAST_BIT) ? 6'h00 : bitIdx_r + 6'h01;
      wordIdx_r <= wordIdx_r + {8'h00, bitIdx_r == LAST_BIT};
      // top sixteen bits only; padding below is ignored
      if (cmdDone)
      begin
        cmdWord_r <= rxTop;
        cmdExt_r <= adc_cmd_pkg::extWords(rxTop);
      end
    end
  end

  // ---------------------------------------------------------------
  // multi write staging: data held until the frame ends
  // ---------------------------------------------------------------
  logic [7:0] stageVal_r [0:adc_cmd_pkg::NUM_REGS-1];
  logic [adc_cmd_pkg::NUM_REGS-1:0] stageHit_r;

  wire [4:0] cA = adc_cmd_pkg::addrOf(cmdWord_r);
  wire [7:0] cN = cmdWord_r[7:0];
  wire [9:0] stOff = {wordIdx_r - 9'h001, 1'b0};
  wire [9:0] stA0 = {5'h00, cA} + stOff;
  wire [9:0] stA1 = stA0 + 10'h001;
  wire stWord = takeBit & (wordIdx_r != 9'h000) & (bitIdx_r == CMD_END)
    & (adc_cmd_pkg::pfxOf(cmdWord_r) == adc_cmd_pkg::PFX_WRS);
  wire stOk0 = inRange(stOff, cN, stA0);
  wire stOk1 = inRange(stOff + 10'h001, cN, stA1);

  // each data word holds bytes for two consecutive registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stageHit_r <= '0;
    else if (csFall)
      stageHit_r <= '0;
    else if (stWord)
    begin
      if (stOk0)
        stageHit_r[stA0[4:0]] <= 1'b1;
      if (stOk1)
        stageHit_r[stA1[4:0]] <= 1'b1;
    end
  end

  // staged bytes need no reset: only the hit bits let them through
  always_ff @(posedge clk)
  begin
    if (stWord & stOk0)
      stageVal_r[stA0[4:0]] <= rxTop[15:8];
    if (stWord & stOk1)
      stageVal_r[stA1[4:0]] <= rxTop[7:0];
  end

  // ---------------------------------------------------------------
  // decode at frame end
  // ---------------------------------------------------------------
  wire [2:0] cPfx = adc_cmd_pkg::pfxOf(cmdWord_r);
  wire isNull = cmdWord_r == adc_cmd_pkg::CMD_NULL;
  wire isReset = cmdWord_r == adc_cmd_pkg::CMD_RESET;
  wire isStby = cmdWord_r == adc_cmd_pkg::CMD_STBY;
  wire isWake = cmdWord_r == adc_cmd_pkg::CMD_WAKE;
  wire isLock = cmdWord_r == adc_cmd_pkg::CMD_LOCK;
  wire isUnlock = cmdWord_r == adc_cmd_pkg::CMD_UNLOCK;
  wire isRd = cPfx == adc_cmd_pkg::PFX_RD;
  wire isWr = cPfx == adc_cmd_pkg::PFX_WR;
  wire isWrs = cPfx == adc_cmd_pkg::PFX_WRS;
  wire known = isNull | isReset | isStby | isWake | isLock | isUnlock
    | isRd | isWr | isWrs;
  // locked and power-on states filter the command set
  wire permit = awaitUnlock ? isUnlock
    : locked ? (isNull | isUnlock | isRd) : 1'b1;
  // only a complete frame is decoded
  wire decode = csRise & frameEnd_r;
  wire act = decode & permit & known;

  wire [15:0] statResp = {adc_cmd_pkg::PFX_RD, adc_cmd_pkg::STAT_ADDR,
    statusIn};
  wire [7:0] wrBack = (cA == adc_cmd_pkg::STAT_ADDR) ? statusIn : cN;
  wire [7:0] rdOne = rdByte({5'h00, cA}, 1'b1, regFile_r[cA], statusIn);
  wire [15:0] rdResp = (cN == 8'h00)
    ? {adc_cmd_pkg::PFX_RD, cA, rdOne}
    : {adc_cmd_pkg::PFX_WRS, cA, cN};
  wire [15:0] respNxt =
    !act ? (awaitUnlock ? READY_W : statResp) :
    isReset ? READY_W :
    isNull ? statResp :
    isRd ? rdResp :
    isWr ? {adc_cmd_pkg::PFX_RD, cA, wrBack} :
    isWrs ? {adc_cmd_pkg::PFX_WR, cA, cN} :
    cmdWord_r;

  // mode flags; a reset command returns to the power-on state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      standby <= 1'b0;
      locked <= 1'b0;
      awaitUnlock <= 1'b1;
      cmdStrobe <= 1'b0;
      lastCmd <= 16'h0000;
      respWord_r <= READY_W;
    end
    else
    begin
      cmdStrobe <= act;
      if (decode)
        respWord_r <= respNxt;
      if (act)
      begin
        lastCmd <= cmdWord_r;
        if (isReset)
        begin
          standby <= 1'b0;
          locked <= 1'b0;
          awaitUnlock <= 1'b1;
        end
        else if (isStby)
          standby <= 1'b1;
        else if (isWake)
          standby <= 1'b0;
        else if (isLock)
          locked <= 1'b1;
        else if (isUnlock)
        begin
          locked <= 1'b0;
          awaitUnlock <= 1'b0;
        end
      end
    end
  end

  // register writes land right after decode; status stays live
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < adc_cmd_pkg::NUM_REGS; i++)
        regFile_r[i] <= adc_cmd_pkg::REG_RST;
    end
    else if (act & isReset)
    begin
      for (int i = 0; i < adc_cmd_pkg::NUM_REGS; i++)
        regFile_r[i] <= adc_cmd_pkg::REG_RST;
    end
    else if (act & isWr)
      regFile_r[cA] <= cN;
    else if (act & isWrs)
    begin
      for (int i = 0; i < adc_cmd_pkg::NUM_REGS; i++)
        if (stageHit_r[i])
          regFile_r[i] <= stageVal_r[i];
    end
  end

  // ---------------------------------------------------------------
  // output shifter
  // ---------------------------------------------------------------
  wire [9:0] rdOff = {wordIdx_r - 9'h001, 1'b0};
  wire [9:0] rdA0 = {5'h00, adc_cmd_pkg::addrOf(respWord_r)} + rdOff;
  wire [9:0] rdA1 = rdA0 + 10'h001;
  wire [7:0] rdB0 = rdByte(rdA0, inRange(rdOff, respWord_r[7:0], rdA0),
    regFile_r[rdA0[4:0]], statusIn);
  wire [7:0] rdB1 = rdByte(rdA1,
    inRange(rdOff + 10'h001, respWord_r[7:0], rdA1),
    regFile_r[rdA1[4:0]], statusIn);
  wire shiftOut = sclkRise & inFrame & started_r & ~frameEnd_r;

  // response loads at frame start, later words on word boundary
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txSr_r <= '0;
      respExt_r <= 8'h00;
      respMulti_r <= 1'b0;
    end
    else if (csFall)
    begin
      txSr_r <= pad(respWord_r);
      respExt_r <= adc_cmd_pkg::extWords(respWord_r);
      respMulti_r <= adc_cmd_pkg::pfxOf(respWord_r)
        == adc_cmd_pkg::PFX_WRS;
    end
    else if (shiftOut)
    begin
      if (bitIdx_r != 6'h00)
        txSr_r <= txSr_r << 1;
      else if (respMulti_r)
        txSr_r <= pad({rdB0, rdB1});
      else
        txSr_r <= '0;  // conversion data is not modelled here
    end
  end

  // held driven until select rises so the last bit can be sampled
  assign link.dout = txSr_r[WORD_BITS-1];
  assign link.doutEn = inFrame;

  // ---------------------------------------------------------------
  // frame-done output
  // ---------------------------------------------------------------
  logic doneN_r;        // line level
  logic doneArm_r;      // delay running
  logic [9:0] doneCnt_r;

  wire [1:0] doneSel = regFile_r[adc_cmd_pkg::DSC_ADDR][1:0];
  wire [9:0] doneDly = 10'(doneSel) * 10'(DONE_STEP);

  // falls after the last bit plus the chosen delay
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      doneN_r <= 1'b1;
      doneArm_r <= 1'b0;
      doneCnt_r <= 10'h000;
    end
    else if (!inFrame)
    begin
      doneN_r <= 1'b1;  // released with own select
      doneArm_r <= 1'b0;
    end
    else if (lastFall)
    begin
      doneArm_r <= 1'b1;
      doneCnt_r <= doneDly;
    end
    else if (doneArm_r)
    begin
      if (doneCnt_r == 10'h000)
        doneN_r <= 1'b0;
      else
        doneCnt_r <= doneCnt_r - 10'h001;
    end
  end

  assign link.doneN = doneN_r;
endmodule

// >>> core/adc_cmd_pkg.sv
/*
  Shared constants for the serial command decoder: command codes,
  field positions, response prefixes, link timing.
  Assumes a 100 MHz system clock on both ends.
*/
package adc_cmd_pkg;
  // ---------------------------------------------------------------
  // command codes and fields
  // ---------------------------------------------------------------
  localparam int CMD_W = 16;
  localparam logic [15:0] CMD_NULL = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_STBY = 16'h0022;
  localparam logic [15:0] CMD_WAKE = 16'h0033;
  localparam logic [15:0] CMD_LOCK = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK = 16'h0655;
  localparam logic [2:0] PFX_RD = 3'h1;   // read / register content
  localparam logic [2:0] PFX_WR = 3'h2;   // single write / multi ack
  localparam logic [2:0] PFX_WRS = 3'h3;  // multi write / multi read
  localparam logic [7:0] READY_HI = 8'hFF;
  localparam logic [4:0] STAT_ADDR = 5'h02;  // fault status register
  localparam logic [4:0] DSC_ADDR = 5'h0B;   // digital_system_config
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int NUM_REGS = 32;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS * CLK_MHZ / 2000;
  localparam int DONE_STEP_NS = 80;  // one done_delay_sel step
  localparam int DONE_STEP_CYC = DONE_STEP_NS * CLK_MHZ / 1000;
  localparam int WORD_BITS_DEF = 24;
  localparam int FRAME_WORDS_DEF = 2;
  localparam int GAP_TICKS = 8;      // idle half periods between frames

  function automatic logic [2:0] pfxOf(input logic [15:0] w);
    pfxOf = w[15:13];
  endfunction

  function automatic logic [4:0] addrOf(input logic [15:0] w);
    addrOf = w[12:8];
  endfunction

  // extra words a multi-register word adds to its frame
  function automatic logic [7:0] extWords(input logic [15:0] w);
    extWords = (w[15:13] == PFX_WRS) ? {1'b0, w[7:1]} : 8'h00;
  endfunction
endpackage

// >>> core/adc_spi_if.sv
/*
  Serial link between command decoder and its controller.
  Assumes the bench joins both modports; dout idles high when undriven.
*/
`timescale 1ns/1ps
interface adc_spi_if;
  logic sclk;    // serial clock, made by the controller
  logic csN;     // frame select, active low
  logic din;     // controller to device
  logic dout;    // device to controller
  logic doutEn;  // device drives dout
  logic doneN;   // frame done, active low
  wire doutLine = doutEn ? dout : 1'b1;  // resolved line level

  modport dev (input sclk, input csN, input din, output dout,
    output doutEn, output doneN);
  modport host (output sclk, output csN, output din, input doutLine,
    input doneN);
endinterface

// >>> core/adc_cmd_host.sv
/*
  Controller end: makes the serial clock, sends one command word per
  frame plus data words, and returns each received word.
  Assumes the user holds dataWord valid until dataTake pulses.
*/
`timescale 1ns/1ps
module adc_cmd_host #(
  parameter int WORD_BITS = adc_cmd_pkg::WORD_BITS_DEF,
  parameter int FRAME_WORDS = adc_cmd_pkg::FRAME_WORDS_DEF,
  parameter int HALF_CYC = adc_cmd_pkg::SCLK_HALF_CYC,
  parameter int GAP = adc_cmd_pkg::GAP_TICKS
)(
  input wire logic clk,
  input wire logic arst_n,
  adc_spi_if.host link,
  input wire logic startValid,
  output logic startReady,
  input wire logic [15:0] cmdWord,
  input wire logic [15:0] dataWord,
  output logic dataTake,
  output logic [15:0] rxWord,
  output logic rxValid,
  output logic rxFirst,
  output logic frameDone
);
  // ---------------------------------------------------------------
  // clock divider and synchronisers
  // ---------------------------------------------------------------
  typedef enum {IDLE, LEAD, HIGH, LOW, TAIL, GAPW} state_e;
  state_e state_r;
  localparam logic [5:0] LAST_BIT = 6'(WORD_BITS - 1);
  localparam logic [5:0] RESP_END = 6'(adc_cmd_pkg::CMD_W - 1);

  logic [7:0] divCnt_r;  // half period counter
  logic doS1, doS2, dnS1, dnS2;

  wire tick = divCnt_r == 8'(HALF_CYC - 1);

  // divider held at zero while idle, so each frame starts in phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      divCnt_r <= 8'h00;
    else if (tick || state_r == IDLE)
      divCnt_r <= 8'h00;
    else
      divCnt_r <= divCnt_r + 8'h01;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      {doS1, doS2, dnS1, dnS2} <= 4'hF;
    else
      {doS1, doS2, dnS1, dnS2} <= {link.doutLine, doS1, link.doneN, dnS1};
  end

  // ---------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------
  logic [5:0] bitIdx_r, rxBit_r;
  logic [8:0] wordIdx_r, rxIdx_r;
  logic [7:0] cmdExt_r, respExt_r;
  logic [7:0] gapCnt_r;
  logic [WORD_BITS-1:0] txSr_r, rxSr_r;
  logic sclk_r, csN_r;

  wire [7:0] extMax = (cmdExt_r > respExt_r) ? cmdExt_r : respExt_r;
  wire [8:0] lastWord = 9'(FRAME_WORDS - 1) + {1'b0, extMax};
  wire lastBit = (wordIdx_r == lastWord) && (bitIdx_r == LAST_BIT);
  wire sample = tick && (state_r == LOW || state_r == TAIL);
  wire [WORD_BITS-1:0] rxNext = {rxSr_r[WORD_BITS-2:0], doS2};
  wire [15:0] rxTop = rxNext[WORD_BITS-1:WORD_BITS-16];
  // command in top bits, zeros below
  wire [WORD_BITS-1:0] cmdPad =
    WORD_BITS'({cmdWord, {WORD_BITS{1'b0}}} >> adc_cmd_pkg::CMD_W);
  wire [WORD_BITS-1:0] dataPad =
    WORD_BITS'({dataWord, {WORD_BITS{1'b0}}} >> adc_cmd_pkg::CMD_W);

  assign startReady = state_r == IDLE;

  // one tick per half period of the serial clock
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= IDLE;
      sclk_r <= 1'b0;
      csN_r <= 1'b1;
      txSr_r <= '0;
      bitIdx_r <= 6'h00;
      wordIdx_r <= 9'h000;
      cmdExt_r <= 8'h00;
      gapCnt_r <= 8'h00;
      dataTake <= 1'b0;
      frameDone <= 1'b0;
    end
    else
    begin
      dataTake <= 1'b0;
      frameDone <= 1'b0;
      case (state_r)
        IDLE:
          if (startValid)
          begin
            csN_r <= 1'b0;
            txSr_r <= cmdPad;
            cmdExt_r <= adc_cmd_pkg::extWords(cmdWord);
            bitIdx_r <= 6'h00;
            wordIdx_r <= 9'h000;
            state_r <= LEAD;
          end
        LEAD:
          if (tick)
          begin
            sclk_r <= 1'b1;
            state_r <= HIGH;
          end
        HIGH:
          if (tick)
          begin
            sclk_r <= 1'b0;  // device takes din here
            bitIdx_r <= (bitIdx_r == LAST_BIT) ? 6'h00 : bitIdx_r + 6'h01;
            wordIdx_r <= wordIdx_r + {8'h00, bitIdx_r == LAST_BIT};
            state_r <= lastBit ? TAIL : LOW;
          end
        LOW:
          if (tick)
          begin
            sclk_r <= 1'b1;
            state_r <= HIGH;
            if (bitIdx_r == 6'h00)
            begin
              txSr_r <= dataPad;  // next data word
              dataTake <= 1'b1;
            end
            else
              txSr_r <= txSr_r << 1;
          end
        TAIL:
          // select rises only once the device signals done
          if (tick && !dnS2)
          begin
            csN_r <= 1'b1;
            frameDone <= 1'b1;
            gapCnt_r <= 8'h00;
            state_r <= GAPW;
          end
        GAPW:
          if (tick)
          begin
            gapCnt_r <= gapCnt_r + 8'h01;
            if (gapCnt_r == 8'(GAP - 1))
              state_r <= IDLE;
          end
        default:
          state_r <= IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receive side: one sample per bit, just before the next rise
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxSr_r <= '0;
      rxBit_r <= 6'h00;
      rxIdx_r <= 9'h000;
      respExt_r <= 8'h00;
      rxWord <= 16'h0000;
      rxValid <= 1'b0;
      rxFirst <= 1'b0;
    end
    else
    begin
      rxValid <= 1'b0;
      if (state_r == IDLE)
      begin
        rxBit_r <= 6'h00;
        rxIdx_r <= 9'h000;
        respExt_r <= 8'h00;
      end
      // ticks repeat while waiting for done; only the last bit counts there
      else if (sample && !(state_r == TAIL && rxBit_r != LAST_BIT))
      begin
        rxSr_r <= rxNext;
        rxBit_r <= (rxBit_r == LAST_BIT) ? 6'h00 : rxBit_r + 6'h01;
        // a multi read answer stretches the frame
        if (rxIdx_r == 9'h000 && rxBit_r == RESP_END)
          respExt_r <= adc_cmd_pkg::extWords(rxNext[15:0]);
        if (rxBit_r == LAST_BIT)
        begin
          rxWord <= rxTop;
          rxValid <= 1'b1;
          rxFirst <= rxIdx_r == 9'h000;
          rxIdx_r <= rxIdx_r + 9'h001;
        end
      end
    end
  end

  assign link.sclk = sclk_r;
  assign link.csN = csN_r;
  assign link.din = txSr_r[WORD_BITS-1];
endmodule

// >>> tb/adc_cmd_props.sv
/*
  Link checker: timing relations of the serial frame lines.
  Assumes every link line is sampled on the system clock.
*/
`timescale 1ns/1ps
module adc_cmd_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic doutEn,
  input wire logic doneN
);
  // ---------------------------------------------------------------
  // frame relations, one clock domain
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // done may only fall in a frame, serial clock parked low
  a_done_framed: assert property ($fell(doneN) |-> !csN && !sclk)
    else $error("done fell outside frame");
  a_done_held: assert property (!doneN && !csN |=> !doneN)
    else $error("done released early");
  a_done_clear: assert property ($rose(csN) |-> ##[1:6] doneN)
    else $error("done not cleared");
  a_csn_chain: assert property ($rose(csN) |-> !doneN)
    else $error("frame closed before done");
  a_drive_start: assert property ($fell(csN) |-> ##[1:6] doutEn)
    else $error("output not driven");
  a_drive_stop: assert property ($rose(csN) |-> ##[1:6] !doutEn)
    else $error("output not released");
  a_sclk_idle: assert property (csN && $past(csN) |-> !sclk)
    else $error("clock outside frame");
  a_drive_hold: assert property (doutEn && !csN |=> doutEn)
    else $error("output dropped in frame");
endmodule

// >>> tb/adc_spi_command_decoder_tb.sv
/*
  Bench: both link ends joined; one command per frame, first word
  received compared with the answer to the previous frame's command.
  Assumes package and interface are compiled first.
*/
`timescale 1ns/1ps
module adc_spi_command_decoder_tb;
  localparam logic [7:0] ID = 8'h3C;  // arbitrary identity value
  localparam logic [15:0] RDY = {8'hFF, ID};
  localparam logic [15:0] ST = 16'h22A5;  // status reg 02h readback
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic startValid = 1'b0;
  logic startReady, dataTake, rxValid, rxFirst, frameDone;
  logic [15:0] cmdWord = 16'h0000;
  logic [15:0] dataWord = 16'h0000;
  logic [15:0] rxWord;
  int num_errors = 0;
  int samples_checked = 0;
  logic standby, locked, awaitUnlock, cmdStrobe;
  logic [15:0] lastCmd;
  logic [15:0] lastExp = 16'h0000;  // last command the device took
  wire [15:0] modeSeen = {13'h0000, standby, locked, awaitUnlock};
  // after each frame: accepted, standby, locked, awaiting unlock
  logic [3:0] modeTab [16] = '{4'h1, 4'h8, 4'hC, 4'h8, 4'h8, 4'h8,
    4'h8, 4'h8, 4'hA, 4'h2, 4'hA, 4'h8, 4'h9, 4'h1, 4'h8, 4'h8};
  // command, first data word, expected answer in this frame
  logic [15:0] tab [16][3] = '{
    '{16'h0000, 16'h0000, RDY},
    '{16'h0655, 16'h0000, RDY},
    '{16'h0022, 16'h0000, 16'h0655},
    '{16'h0033, 16'h0000, 16'h0022},
    '{16'h4B01, 16'h0000, 16'h0033},
    '{16'h2B00, 16'h0000, 16'h2B01},
    '{16'h6402, 16'hC3D2, 16'h2B01},
    '{16'h2402, 16'h0000, 16'h4402},
    '{16'h0555, 16'h0000, 16'h6402},
    '{16'h4B02, 16'h0000, 16'h0555},
    '{16'h2B00, 16'h0000, ST},
    '{16'h0655, 16'h0000, 16'h2B01},
    '{16'h0011, 16'h0000, 16'h0655},
    '{16'h0000, 16'h0000, RDY},
    '{16'h0655, 16'h0000, RDY},
    '{16'h0000, 16'h0000, 16'h0655}
  };
  // ---------------------------------------------------------------
  // both ends and the checker on one link
  // ---------------------------------------------------------------
  adc_spi_if link();
  adc_cmd_dev #(.DEV_ID(ID)) adc_cmd_dev_inst (.clk, .arst_n, .link(link),
    .statusIn(8'hA5), .standby, .locked, .awaitUnlock, .cmdStrobe,
    .lastCmd);
  adc_cmd_host adc_cmd_host_inst (.clk, .arst_n, .link(link), .startValid,
    .startReady, .cmdWord, .dataWord, .dataTake, .rxWord, .rxValid,
    .rxFirst, .frameDone);
  adc_cmd_props adc_cmd_props_inst (.clk, .arst_n, .sclk(link.sclk),
    .csN(link.csN), .doutEn(link.doutEn), .doneN(link.doneN));
  always #5 clk = ~clk;
  // later data words: reg 6 of the multi write; reg 7 lies past its count
  always @(posedge clk) if (dataTake) dataWord <= 16'hE100;
  task automatic chk(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one frame; e1 nonzero also checks the second received word,
  // ew is the number of words the frame must carry
  task automatic run(input logic [15:0] c, d, e, e1, input int ew);
    int w;
    bit fin;
    w = 0;
    fin = 1'b0;
    @(posedge clk) #1;
    while (startReady !== 1'b1) @(posedge clk) #1;
    cmdWord = c;
    dataWord = d;
    startValid = 1'b1;
    @(posedge clk) #1;
    startValid = 1'b0;
    for (int k = 0; k < 2000 && !fin; k++)
    begin
      @(posedge clk) #1;
      if (rxValid === 1'b1 && rxFirst === 1'b1) chk(rxWord, e);
      else if (rxValid === 1'b1 && e1 !== 16'h0 && w == 1)
        chk(rxWord, e1);
      w += int'(rxValid === 1'b1);
      fin = (frameDone === 1'b1);
    end
    // a frame that never closes is a failure by itself
    if (!fin)
      num_errors++;
    chk(16'(w), 16'(ew));
  endtask
  initial
  begin
    int st;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    foreach (tab[i])
    begin
      run(tab[i][0], tab[i][1], tab[i][2], i == 8 ? 16'hC3D2 : 16'h0,
        (i == 6 || i == 8) ? 3 : 2);
      // decode lands three clocks after select rises, inside the gap
      st = 0;
      repeat (4)
      begin
        @(posedge clk) #1;
        st += int'(cmdStrobe === 1'b1);
      end
      if (modeTab[i][3])
        lastExp = tab[i][0];
      chk(16'(st), 16'(modeTab[i][3]));
      chk(lastCmd, lastExp);
      chk(modeSeen, {13'h0000, modeTab[i][2:0]});
    end
    stop_test();
  end
  // hang guard, well past sixteen frames
  initial
  begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule
